// file: rtl/psr_avalon_slave.sv
`timescale 1ns/1ps
// Avalon-MM front end: accepts each access after one wait cycle.
module psr_avalon_slave (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic read_i,
  input wire logic write_i,
  output logic waitrequest_o,
  output logic acc_rd_o,
  output logic acc_wr_o
);
  logic ack_r;
  wire req = read_i | write_i;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end
  assign waitrequest_o = req & ~ack_r;
  assign acc_rd_o = read_i & ack_r;
  assign acc_wr_o = write_i & ack_r;
endmodule

// file: rtl/psr_field_reg.sv
`timescale 1ns/1ps
// One writable setpoint; only bits inside the mask can ever change.
module psr_field_reg #(
  parameter logic [15:0] MASK = 16'hffff,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] q_o
);
  logic [15:0] q_r;
  logic [15:0] q_nxt;
  assign q_nxt = wr_i ? (wdata_i & MASK) : q_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q_r <= RESET_VAL & MASK;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q_o = q_r;
endmodule

// file: rtl/psr_map.svh
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
// Register indices; byte address is four times the index.
`define PSR_IDX_PASSWORD 20'h62638
`define PSR_IDX_GROUP 20'h62639
`define PSR_IDX_RATING 20'h6263a
`define PSR_IDX_FRAME 20'h6263b
`define PSR_IDX_CAP1 20'h6263c
`define PSR_IDX_CAP2 20'h6263d
`define PSR_IDX_LD_MEM 20'h6263e
`define PSR_IDX_ZONE 20'h6263f
`define PSR_IDX_LD_SLOPE 20'h62640
`define PSR_IDX_LD_PICKUP 20'h62641
`define PSR_IDX_LD_TIME 20'h62642
`define PSR_IDX_HL_ALARM 20'h62643
`define PSR_IDX_SD_SLOPE 20'h62644
`define PSR_IDX_SD_PICKUP 20'h62645
`define PSR_IDX_SD_TIME 20'h62646
`define PSR_IDX_INST_PICKUP 20'h62647
`define PSR_IDX_GND_MODE 20'h62648
`define PSR_IDX_GF_ACTION 20'h62649
`define PSR_IDX_GF_SLOPE 20'h6264a
`define PSR_IDX_GF_PICKUP 20'h6264b
// Field masks.
`define PSR_MASK_FULL 16'hffff
`define PSR_MASK_BIT 16'h0001
`define PSR_MASK_TWO 16'h0003
`define PSR_MASK_RATING 16'h1fff
`define PSR_MASK_FRAME 16'h0007
`define PSR_MASK_CAP1 16'h33ff
`define PSR_MASK_CAP2 16'h000f
// Reset values.
`define PSR_RST_ZERO 16'h0000
`define PSR_RST_GROUP 16'h00ff
`define PSR_RST_HL_ALARM 16'h0064
// High-load alarm legal range in percent.
`define PSR_HL_MIN 16'h0064
`define PSR_HL_MAX 16'h006e
// Capability bit positions.
`define PSR_CAP_LD 0
`define PSR_CAP_SD 1
`define PSR_CAP_INST 2
`define PSR_CAP_GF 3
`define PSR_CAP_MAINT 4
`define PSR_CAP_OVR 5
`define PSR_CAP_RCD 6
`define PSR_CAP_MOTOR 7
`define PSR_CAP_NEUT 8
`define PSR_CAP_HEAT 9
`define PSR_CAP_VOLT 12
`define PSR_CAP_EXTC 13
// Slope and ground action encodings.
`define PSR_LD_SQUARED 2'h2
`define PSR_LD_FOURTH 2'h3
`define PSR_GF_ACT_OFF 2'h2
`endif

// file: rtl/psr_pkg.sv
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_LD_SQRT,
    PSR_LD_LINEAR,
    PSR_LD_SQ,
    PSR_LD_FOURTH_P
  } psr_ld_curve_e;
  typedef enum logic [1:0] {
    PSR_GF_TRIP,
    PSR_GF_ALARM,
    PSR_GF_OFF,
    PSR_GF_RSVD
  } psr_gf_action_e;
  typedef struct packed {
    logic has_long_delay;
    logic has_short_delay;
    logic has_instant_trip;
    logic has_ground_fault;
    logic has_maintenance_option;
    logic has_override;
    logic has_residual_current_option;
    logic has_motor_protection;
    logic has_neutral_sensor;
    logic has_heat_memory;
    logic has_voltage_sampling;
    logic has_external_converter;
  } psr_caps_s;
  typedef struct packed {
    logic heat_memory_active;
    logic zone_interlock_short;
    logic zone_interlock_ground;
    psr_ld_curve_e long_delay_curve;
    logic [15:0] long_delay_pickup_current;
    logic [15:0] long_delay_time;
    logic [15:0] high_load_alarm_level;
    logic short_delay_curve;
    logic [15:0] short_delay_pickup;
    logic [15:0] short_delay_time_ms;
    logic [15:0] instant_pickup_current;
    psr_gf_action_e ground_fault_action;
    logic ground_fault_curve;
    logic [15:0] ground_pickup_current;
  } psr_settings_s;
endpackage

// file: rtl/psr_setpoint_bank.sv
`timescale 1ns/1ps
//
// Contract
// RL1 - Capability word one bits 0 to 3 report long delay, short delay, instantaneous and ground fault.
// RL2 - Capability word one bits 4 to 7 report maintenance, override, residual current and motor.
// RL3 - Capability word one bits 8, 9, 12 and 13 report neutral, heat memory, voltage and converter.
// RL4 - The long delay memory bit is read/write and only acts for the squared and fourth-power curves.
// RL5 - With zone interlock set and ground fault fitted, interlock covers short delay and ground.
// RL6 - With zone interlock set and no ground fault, interlock covers short delay only.
// RL7 - The long delay slope is a two-bit field selecting root, linear, squared or fourth power.
// RL8 - The high load alarm level is a percent accepted only from 100 to 110.
// RL9 - Short delay pickup is held in tenths of the long delay pickup.
// RL10 - Short delay time is held in milliseconds.
// RL11 - Instantaneous pickup is held in tenths of rated current.
// RL12 - Ground pickup is held in hundredths of rated current.
// RL13 - Ground sensing mode is read-only and always reads residual, zero.
// RL14 - Ground fault action is a two-bit field: trip, alarm or off.
// RL15 - Ground fault slope is one bit: flat or squared.
// RL16 - Writes to read-only registers and to bits outside each mask are ignored.
// RL17 - The password register reads as zero.
`include "psr_map.svh"
module psr_setpoint_bank #(
  parameter int ADDR_W = 22,
  parameter logic [12:0] RATING = 13'h0000,
  parameter logic [2:0] FRAME = 3'h0,
  parameter logic [15:0] CAPS_ONE = 16'h000f,
  parameter logic [3:0] CAPS_TWO = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output psr_pkg::psr_caps_s caps_o,
  output psr_pkg::psr_settings_s settings_o,
  output logic hl_alarm_rejected_o
);
  import psr_pkg::*;

  // The word index needs twenty bits above the two byte bits, and the bus is 32 bits wide.
  if (ADDR_W < 22 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must cover the register indices");
  end

  localparam int NREG = 20;
  localparam logic [19:0] BASE = `PSR_IDX_PASSWORD;

  logic acc_rd;
  logic acc_wr;
  psr_avalon_slave u_slave (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .waitrequest_o(avs_waitrequest_o),
    .acc_rd_o(acc_rd),
    .acc_wr_o(acc_wr)
  );

  // Word address; the low two byte bits must be zero for a hit.
  wire [ADDR_W-3:0] idx = avs_address_i[ADDR_W-1:2];
  wire aligned = avs_address_i[1:0] == 2'b00;
  wire [19:0] idx20 = idx[19:0];
  wire hi_zero = (idx >> 20) == '0;
  wire in_range = aligned && hi_zero && idx20 >= BASE && idx20 < BASE + 20'(NREG);
  wire [4:0] sel = 5'(idx20 - BASE);
  wire [15:0] wd = avs_writedata_i[15:0];

  // The alarm level only accepts values inside its legal percent range.
  wire hl_ok = wd >= `PSR_HL_MIN && wd <= `PSR_HL_MAX; // [RL8]
  // Ground action code 3 is not defined and is dropped rather than stored.
  wire gf_ok = wd[1:0] <= `PSR_GF_ACT_OFF; // [RL14]

  logic [NREG-1:0] wr_en;
  logic [15:0] store_r [NREG];
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      // The password and the read-only words keep nothing, so no write can reach them.
      if (g == 0 || g == 2 || g == 3 || g == 4 || g == 5 || g == 16) begin : g_ro
        assign wr_en[g] = 1'b0; // [RL13] [RL16] [RL17]
        assign store_r[g] = `PSR_RST_ZERO;
      end else begin : g_rw
        localparam logic [15:0] FMASK = (g == 6 || g == 7 || g == 12 || g == 18) ?
          `PSR_MASK_BIT : (g == 8 || g == 17) ? `PSR_MASK_TWO : `PSR_MASK_FULL; // [RL4] [RL7] [RL14] [RL15]
        localparam logic [15:0] FRST = (g == 1) ? `PSR_RST_GROUP :
          (g == 11) ? `PSR_RST_HL_ALARM : `PSR_RST_ZERO;
        wire ok = (g == 11) ? hl_ok : (g == 17) ? gf_ok : 1'b1;
        assign wr_en[g] = acc_wr && in_range && sel == 5'(g) && ok; // [RL16]
        psr_field_reg #(
          .MASK(FMASK),
          .RESET_VAL(FRST)
        ) u_f (
          .clk_i(clk_i),
          .rst_b_i(rst_b_i),
          .wr_i(wr_en[g]),
          .wdata_i(wd),
          .q_o(store_r[g])
        );
      end
    end
  endgenerate

  // Rating, frame and capability words come from straps; ground mode is fixed at zero; the password never reads back.
  wire [15:0] cap1 = CAPS_ONE & `PSR_MASK_CAP1; // [RL1] [RL2] [RL3]
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (in_range) begin
      unique case (sel)
        5'd0: rd_word = 16'h0000; // [RL17]
        5'd2: rd_word = {3'h0, RATING} & `PSR_MASK_RATING;
        5'd3: rd_word = {13'h0, FRAME} & `PSR_MASK_FRAME;
        5'd4: rd_word = cap1;
        5'd5: rd_word = {12'h0, CAPS_TWO} & `PSR_MASK_CAP2;
        5'd16: rd_word = 16'h0000; // [RL13]
        default: rd_word = store_r[sel];
      endcase
    end
  end

  logic [31:0] rdata_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      rdata_r <= {16'h0, rd_word};
    end
  end
  assign avs_readdata_o = rdata_r;

  logic rej_r;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rej_r <= 1'b0;
    end else begin
      rej_r <= acc_wr && in_range && sel == 5'd11 && !hl_ok;
    end
  end
  assign hl_alarm_rejected_o = rej_r;

  // Capability straps onto the named flags.
  assign caps_o.has_long_delay = cap1[`PSR_CAP_LD]; // [RL1]
  assign caps_o.has_short_delay = cap1[`PSR_CAP_SD];
  assign caps_o.has_instant_trip = cap1[`PSR_CAP_INST];
  assign caps_o.has_ground_fault = cap1[`PSR_CAP_GF];
  assign caps_o.has_maintenance_option = cap1[`PSR_CAP_MAINT]; // [RL2]
  assign caps_o.has_override = cap1[`PSR_CAP_OVR];
  assign caps_o.has_residual_current_option = cap1[`PSR_CAP_RCD];
  assign caps_o.has_motor_protection = cap1[`PSR_CAP_MOTOR];
  assign caps_o.has_neutral_sensor = cap1[`PSR_CAP_NEUT]; // [RL3]
  assign caps_o.has_heat_memory = cap1[`PSR_CAP_HEAT];
  assign caps_o.has_voltage_sampling = cap1[`PSR_CAP_VOLT];
  assign caps_o.has_external_converter = cap1[`PSR_CAP_EXTC];

  // Heat memory only matters on the steep curves.
  wire [1:0] ld_curve = store_r[8][1:0];
  wire steep = ld_curve == `PSR_LD_SQUARED || ld_curve == `PSR_LD_FOURTH;
  wire zone_on = store_r[7][0];
  assign settings_o.heat_memory_active = store_r[6][0] & steep; // [RL4]
  assign settings_o.zone_interlock_short = zone_on; // [RL5] [RL6]
  assign settings_o.zone_interlock_ground = zone_on & cap1[`PSR_CAP_GF]; // [RL5] [RL6]
  assign settings_o.long_delay_curve = psr_ld_curve_e'(ld_curve); // [RL7]
  assign settings_o.long_delay_pickup_current = store_r[9];
  assign settings_o.long_delay_time = store_r[10];
  assign settings_o.high_load_alarm_level = store_r[11]; // [RL8]
  assign settings_o.short_delay_curve = store_r[12][0];
  assign settings_o.short_delay_pickup = store_r[13]; // [RL9]
  assign settings_o.short_delay_time_ms = store_r[14]; // [RL10]
  assign settings_o.instant_pickup_current = store_r[15]; // [RL11]
  assign settings_o.ground_fault_action = psr_gf_action_e'(store_r[17][1:0]); // [RL14]
  assign settings_o.ground_fault_curve = store_r[18][0]; // [RL15]
  assign settings_o.ground_pickup_current = store_r[19]; // [RL12]

  chk_hl_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    store_r[11] >= `PSR_HL_MIN && store_r[11] <= `PSR_HL_MAX) // [RL8]
    else $error("alarm level out of range");
  chk_ro_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_wr && in_range && (sel == 5'd2 || sel == 5'd4 || sel == 5'd16) |-> wr_en == '0) // [RL16]
    else $error("read-only register written");
  chk_pw_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_rd && in_range && sel == 5'd0 |-> avs_readdata_o == 32'h0) // [RL17]
    else $error("password exposed");
  chk_gnd_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_rd && in_range && sel == 5'd16 |-> avs_readdata_o == 32'h0) // [RL13]
    else $error("sensing mode not residual");
  chk_mask_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[8] |=> store_r[8] == ($past(wd) & `PSR_MASK_TWO)) // [RL7]
    else $error("slope write not masked");
  chk_zone_gnd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    settings_o.zone_interlock_ground |-> zone_on && caps_o.has_ground_fault) // [RL5]
    else $error("ground interlock without fault option");
  chk_zone_sd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    zone_on |-> settings_o.zone_interlock_short) // [RL6]
    else $error("short delay interlock missing");
  chk_heat_mem: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    settings_o.heat_memory_active |-> store_r[6][0] && ld_curve[1]) // [RL4]
    else $error("heat memory on a flat curve");
  chk_gf_action: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    store_r[17][1:0] != 2'h3) // [RL14]
    else $error("undefined ground action stored");
  chk_wait_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait longer than one cycle");

  // An access is a new request held through one wait cycle, then taken.
  sequence s_new_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_accept;
    !avs_waitrequest_o && (acc_rd || acc_wr);
  endsequence
  chk_bus_accept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_new_req |=> s_accept)
    else $error("request not taken after one wait cycle");
  chk_rd_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_rd |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_rd_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  chk_hl_reject: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_wr && in_range && sel == 5'd11 && !hl_ok |=>
      hl_alarm_rejected_o && $stable(store_r[11])) // [RL8]
    else $error("refused alarm level not flagged or stored");
  chk_gf_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    acc_wr && in_range && sel == 5'd17 && !gf_ok |=> $stable(store_r[17])) // [RL14]
    else $error("undefined ground action changed the field");
  chk_mem_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[6] |=> store_r[6] == ($past(wd) & `PSR_MASK_BIT)) // [RL4]
    else $error("memory bit write not masked");
  chk_gf_slope: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[18] |=> store_r[18] == ($past(wd) & `PSR_MASK_BIT)) // [RL15]
    else $error("ground slope write not masked");
  chk_sd_pickup: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[13] |=> store_r[13] == $past(wd)) // [RL9]
    else $error("short pickup not stored whole");
  chk_sd_time: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[14] |=> store_r[14] == $past(wd)) // [RL10]
    else $error("short time not stored whole");
  chk_inst_pickup: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[15] |=> store_r[15] == $past(wd)) // [RL11]
    else $error("instant pickup not stored whole");
  chk_gnd_pickup: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en[19] |=> store_r[19] == $past(wd)) // [RL12]
    else $error("ground pickup not stored whole");
  chk_zone_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !zone_on |-> !settings_o.zone_interlock_short && !settings_o.zone_interlock_ground) // [RL5]
    else $error("interlock active while disabled");
endmodule

// file: tb/test_protection_setpoint_registers.sv
`timescale 1ns/1ps
`include "psr_map.svh"
module test_protection_setpoint_registers;
  import psr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [21:0] avs_address_i = 22'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] rdata;
  logic wait_a;
  logic rej;
  psr_caps_s caps;
  psr_caps_s caps_b;
  psr_settings_s set_a;
  psr_settings_s set_b;
  int fail_count = 0;
  int comparisons = 0;

  // Second bank has no ground fault fitted, so interlock scope can be compared.
  psr_setpoint_bank #(.ADDR_W(22), .RATING(13'h1abc), .FRAME(3'h5), .CAPS_ONE(16'hffad),
    .CAPS_TWO(4'ha)) i_psr_setpoint_bank (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_a),
    .caps_o(caps), .settings_o(set_a), .hl_alarm_rejected_o(rej));
  psr_setpoint_bank #(.ADDR_W(22), .CAPS_ONE(16'h0003)) i_psr_setpoint_bank_b (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(), .avs_waitrequest_o(), .caps_o(caps_b), .settings_o(set_b),
    .hl_alarm_rejected_o());

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // Waitrequest and read data are read right after the rising edge, before the
  // design's flops take their new values, so both show what that edge sampled.
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_a !== 1'b0 && n < 50);
    q = rdata[15:0];
    if (wait_a !== 1'b0) begin
      fail_count++;
      $display("BAD %0t access never answered", $time);
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [19:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    chk16(q, exp);
  endtask

  task automatic t_reset;
    rd_chk(`PSR_IDX_GROUP, 16'h00ff);
    rd_chk(`PSR_IDX_HL_ALARM, 16'h0064);
    rd_chk(`PSR_IDX_GND_MODE, 16'h0000);
    wr(`PSR_IDX_PASSWORD, 16'h1234);
    rd_chk(`PSR_IDX_PASSWORD, 16'h0000);
    wr(`PSR_IDX_GND_MODE, 16'hffff);
    rd_chk(`PSR_IDX_GND_MODE, 16'h0000);
    rd_chk(20'h62650, 16'h0000);
  endtask

  task automatic t_caps;
    rd_chk(`PSR_IDX_CAP1, 16'h33ad);
    wr(`PSR_IDX_CAP1, 16'h0000);
    rd_chk(`PSR_IDX_CAP1, 16'h33ad);
    rd_chk(`PSR_IDX_CAP2, 16'h000a);
    rd_chk(`PSR_IDX_RATING, 16'h1abc);
    rd_chk(`PSR_IDX_FRAME, 16'h0005);
    chk16({4'h0, caps}, 16'h0b5f);
    chk16({4'h0, caps_b}, 16'h0c00);
  endtask

  task automatic t_fields;
    logic [19:0] ix [12] = '{`PSR_IDX_GROUP, `PSR_IDX_LD_MEM, `PSR_IDX_ZONE,
      `PSR_IDX_LD_SLOPE, `PSR_IDX_LD_PICKUP, `PSR_IDX_LD_TIME, `PSR_IDX_SD_SLOPE,
      `PSR_IDX_SD_PICKUP, `PSR_IDX_SD_TIME, `PSR_IDX_INST_PICKUP, `PSR_IDX_GF_SLOPE,
      `PSR_IDX_GF_PICKUP};
    logic [15:0] ex [12] = '{16'hffff, 16'h0001, 16'h0001, 16'h0003, 16'hffff, 16'hffff,
      16'h0001, 16'hffff, 16'hffff, 16'hffff, 16'h0001, 16'hffff};
    for (int i = 0; i < 12; i++) begin
      wr(ix[i], 16'hffff);
      rd_chk(ix[i], ex[i]);
    end
    wr(`PSR_IDX_SD_PICKUP, 16'h0019);
    wr(`PSR_IDX_SD_TIME, 16'h01f4);
    wr(`PSR_IDX_INST_PICKUP, 16'h0064);
    wr(`PSR_IDX_GF_PICKUP, 16'h0032);
    wr(`PSR_IDX_GF_SLOPE, 16'h0000);
    @(negedge clk_i);
    chk16(set_a.short_delay_pickup, 16'h0019);
    chk16(set_a.short_delay_time_ms, 16'h01f4);
    chk16(set_a.instant_pickup_current, 16'h0064);
    chk16(set_a.ground_pickup_current, 16'h0032);
    chk1(set_a.ground_fault_curve, 1'b0);
    chk16(set_a.long_delay_pickup_current, 16'hffff);
    chk16(set_a.long_delay_time, 16'hffff);
    chk1(set_a.short_delay_curve, 1'b1);
  endtask

  task automatic t_alarm;
    logic [15:0] v [4] = '{16'h0063, 16'h006e, 16'h006f, 16'h0064};
    logic [15:0] e [4] = '{16'h0064, 16'h006e, 16'h006e, 16'h0064};
    logic r [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic seen;
    for (int i = 0; i < 4; i++) begin
      wr(`PSR_IDX_HL_ALARM, v[i]);
      seen = 1'b0;
      repeat (3) begin
        @(negedge clk_i);
        seen = seen | rej;
      end
      chk1(seen, r[i]);
      rd_chk(`PSR_IDX_HL_ALARM, e[i]);
      chk16(set_a.high_load_alarm_level, e[i]);
    end
  endtask

  task automatic t_action;
    for (int a = 0; a < 3; a++) begin
      wr(`PSR_IDX_GF_ACTION, 16'(a));
      rd_chk(`PSR_IDX_GF_ACTION, 16'(a));
      chk16({14'h0, set_a.ground_fault_action}, 16'(a));
    end
    wr(`PSR_IDX_GF_ACTION, 16'h0003);
    rd_chk(`PSR_IDX_GF_ACTION, 16'h0002);
  endtask

  task automatic t_zone;
    for (int z = 1; z >= 0; z--) begin
      wr(`PSR_IDX_ZONE, 16'(z));
      @(negedge clk_i);
      chk1(set_a.zone_interlock_short, 1'(z));
      chk1(set_a.zone_interlock_ground, 1'(z));
      chk1(set_b.zone_interlock_short, 1'(z));
      chk1(set_b.zone_interlock_ground, 1'b0);
    end
  endtask

  // Memory only acts on the squared and fourth-power curves, so every curve is tried.
  task automatic t_memory;
    wr(`PSR_IDX_LD_MEM, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(`PSR_IDX_LD_SLOPE, 16'(c));
      @(negedge clk_i);
      chk1(set_a.heat_memory_active, c >= 2);
      chk16({14'h0, set_a.long_delay_curve}, 16'(c));
    end
    wr(`PSR_IDX_LD_MEM, 16'h0000);
    @(negedge clk_i);
    chk1(set_a.heat_memory_active, 1'b0);
  endtask

  // A second reset in mid-run must bring written words back to their start values.
  task automatic t_rerun;
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_chk(`PSR_IDX_LD_SLOPE, 16'h0000);
    rd_chk(`PSR_IDX_GF_PICKUP, 16'h0000);
    rd_chk(`PSR_IDX_GROUP, 16'h00ff);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_caps;
    t_fields;
    t_alarm;
    t_action;
    t_zone;
    t_memory;
    t_rerun;
    give_verdict;
  end

  // About seventy accesses of a few cycles each; this span leaves wide margin.
  initial begin
    #200000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict;
  end
endmodule
